// >>> hw/dctc_down_counter.sv
`timescale 1ns/10ps
`default_nettype none

// Eight-bit down counter; initial value 0 means 256
module dctc_down_counter (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic       run,
  input  wire logic       step,
  input  wire logic       modulo,
  input  wire logic [7:0] init,
  output logic [7:0]      value,
  output logic            active,
  output logic            eoc
);

  logic last;

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  assign last = (value == 8'h01);

  // Load wins over a step in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      value  <= 8'h00;
      active <= 1'b0;
      eoc    <= 1'b0;
    end
    else
    begin
      eoc <= 1'b0;
      if (load)
      begin
        value  <= init;
        active <= 1'b1;
      end
      else if (run && active && step)
      begin
        if (last)
        begin
          eoc <= 1'b1;
          value <= modulo ? init : 8'h00;   // see R14
          active <= modulo;                 // see R14
        end
        else
          value <= value - 8'h01;           // 00h wraps to FFh: 256 counts
      end
    end
  end

endmodule : dctc_down_counter

`default_nettype wire

// >>> hw/dctc_pkg.sv
package dctc_pkg;

  // ----------------------------------------------------------------
  // Register word indices (byte address is index*4)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_TIMER_MODE   = 8'hF1;
  localparam logic [7:0]  IDX_COUNT1       = 8'hF2;
  localparam logic [7:0]  IDX_PRESCALE1    = 8'hF3;
  localparam logic [7:0]  IDX_COUNT0       = 8'hF4;
  localparam logic [7:0]  IDX_PRESCALE0    = 8'hF5;
  localparam logic [7:0]  IDX_IRQ_STATUS   = 8'hF6;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'hF7;
  localparam int          ADDR_W           = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          TM_IN_MODE_LO    = 4;
  localparam int          TM_C1_EN         = 3;
  localparam int          TM_C1_LOAD       = 2;
  localparam int          TM_C0_EN         = 1;
  localparam int          TM_C0_LOAD       = 0;
  localparam int          PS_DIV_LO        = 2;
  localparam int          PS_CLK_SRC       = 1;
  localparam int          PS_MODULO        = 0;
  localparam int          IRQ_C0_BIT       = 4;
  localparam int          IRQ_C1_BIT       = 5;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  TIMER_MODE_RST   = 8'h00;
  localparam logic [7:0]  COUNT_RST        = 8'h00;
  localparam logic [5:0]  DIV_RST          = 6'h00;
  localparam logic [7:0]  IRQ_MASK_RST     = 8'h00;
  localparam real         CLK_MHZ          = 25.0;
  localparam real         TCLK_NS          = 160.0;
  localparam int          TCLK_CYCLES      = (TCLK_NS * CLK_MHZ / 1000.0 < 1.0) ? 1 :
                                             int'($floor(TCLK_NS * CLK_MHZ / 1000.0));

  // External timing input use
  typedef enum logic [1:0] {
    DCTC_IN_CLOCK   = 2'h0,
    DCTC_IN_GATE    = 2'h1,
    DCTC_IN_TRIG    = 2'h2,
    DCTC_IN_RETRIG  = 2'h3
  } dctc_in_mode_t;

  typedef enum logic [1:0] {
    DCTC_RESP_OKAY   = 2'h0,
    DCTC_RESP_SLVERR = 2'h2
  } dctc_resp_t;

endpackage : dctc_pkg

// >>> hw/dctc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

// Six-bit prescaler: one pulse per 'div' input ticks, 0 means 64
module dctc_prescaler (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       restart,
  input  wire logic       tick,
  input  wire logic [5:0] div,
  output logic            pulse
);

  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       wrap;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Count 0..div-1; 6-bit wrap makes div=0 a full 64
  assign wrap  = tick && (cnt_q + 6'h1 == div);
  assign cnt_d = restart ? 6'h0 : (wrap ? 6'h0 : (tick ? cnt_q + 6'h1 : cnt_q));

  // Counter and output pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= 6'h0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pulse <= wrap && !restart;
    end
  end

endmodule : dctc_prescaler

`default_nettype wire

// >>> hw/dctc_top.sv
// How it works
// R1: Mode bits 5..4 pick external input use: clock, gate, trigger, retrigger.
// R2: Mode bit 3 enables counter one counting; resets clear.
// R3: Mode bit 1 enables counter zero counting; resets clear.
// R4: Writing one to mode bit 2 loads counter one; zero does nothing.
// R5: Writing one to mode bit 0 loads counter zero; zero does nothing.
// R6: Counter one register reads live value, writes initial value; 00h means 256.
// R7: Counter zero register reads live value, writes initial value; 00h means 256.
// R8: Prescale1 bits 7..2 set divide 1 to 64; zero means 64.
// R9: Prescale0 bits 7..2 set divide 1 to 64; zero means 64.
// R10: Prescale1 bit 1 picks internal clock (1) or external input (0).
// R11: Prescale bit 0 picks single pass (0) or modulo-N (1).
// R12: End of count sets irq bit 5 (counter one) or 4 (zero).
// R13: Counters keep running while core clock halts; irqs wake core.
// R14: Single pass stops at end; modulo-N reloads and continues.
// R15: Software writes zeros to reserved mode and prescale bits.
`timescale 1ns/10ps
`default_nettype none

module dctc_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        external_timing_input,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             counter_zero_irq,
  output logic             counter_one_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  timer_mode_ctrl_q;
  logic [7:0]  init1_q;
  logic [7:0]  init0_q;
  logic [5:0]  div1_q;
  logic [5:0]  div0_q;
  logic        clk_src1_q;
  logic        modulo1_q;
  logic        modulo0_q;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_mask_q;

  // AXI write side holding
  logic        aw_held_q;
  logic        w_held_q;
  logic [9:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hit

  logic        wr_fire;
  logic        wr_en;
  logic        wr_mode;
  logic        wr_cnt1;
  logic        wr_prescale1_ctrl;
  logic        wr_cnt0;
  logic        wr_prescale0_ctrl;
  logic        wr_mask;
  logic        wr_ok;
  logic        rd_fire;
  logic        rd_ok;
  logic        rd_status;
  logic [7:0]  wbyte;

  // Write fires once both halves are held and the response slot is free
  assign wr_fire  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_en    = wr_fire && wstrb0_q;
  assign wbyte    = wdata_q[7:0];
  assign wr_mode  = wr_en && hit(awaddr_q, dctc_pkg::IDX_TIMER_MODE);
  assign wr_cnt1  = wr_en && hit(awaddr_q, dctc_pkg::IDX_COUNT1);
  assign wr_prescale1_ctrl  = wr_en && hit(awaddr_q, dctc_pkg::IDX_PRESCALE1);
  assign wr_cnt0  = wr_en && hit(awaddr_q, dctc_pkg::IDX_COUNT0);
  assign wr_prescale0_ctrl  = wr_en && hit(awaddr_q, dctc_pkg::IDX_PRESCALE0);
  assign wr_mask  = wr_en && hit(awaddr_q, dctc_pkg::IDX_IRQ_MASK);
  assign wr_ok    = hit(awaddr_q, dctc_pkg::IDX_TIMER_MODE) || hit(awaddr_q, dctc_pkg::IDX_COUNT1)
                 || hit(awaddr_q, dctc_pkg::IDX_PRESCALE1) || hit(awaddr_q, dctc_pkg::IDX_COUNT0)
                 || hit(awaddr_q, dctc_pkg::IDX_PRESCALE0) || hit(awaddr_q, dctc_pkg::IDX_IRQ_MASK)
                 || hit(awaddr_q, dctc_pkg::IDX_IRQ_STATUS);
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rd_status = rd_fire && hit(s_axi_araddr, dctc_pkg::IDX_IRQ_STATUS);

  // ----------------------------------------------------------------
  // Time base and external input
  // ----------------------------------------------------------------
  logic [7:0]  tb_cnt_q;
  logic        tclk_tick;
  logic        ext_meta_q;
  logic        ext_sync_q;
  logic        ext_prev_q;
  logic        ext_rise;

  // Internal timer clock; runs regardless of core halt (see R13)
  assign tclk_tick = (tb_cnt_q == 8'(dctc_pkg::TCLK_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (srst)
      tb_cnt_q <= 8'h00;
    else
      tb_cnt_q <= tclk_tick ? 8'h00 : tb_cnt_q + 8'h01;
  end

  // Two-stage synchroniser, then edge detect on the second stage only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= external_timing_input;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Falling edge is the active edge, as for a low-going trigger
  assign ext_rise = !ext_sync_q && ext_prev_q;

  // ----------------------------------------------------------------
  // Counter one input selection
  // ----------------------------------------------------------------
  dctc_pkg::dctc_in_mode_t in_mode;
  logic        c1_tick;
  logic        c1_load;
  logic        c1_trig_load;
  logic        c1_fired_q;
  logic        c1_active;
  logic        c0_load;

  assign in_mode = dctc_pkg::dctc_in_mode_t'(timer_mode_ctrl_q[dctc_pkg::TM_IN_MODE_LO +: 2]); // see R1

  // Gate counts internal clock while input is high; triggers start counting
  assign c1_tick = clk_src1_q ? tclk_tick                                        // see R10
                 : (in_mode == dctc_pkg::DCTC_IN_CLOCK) ? ext_rise
                 : (in_mode == dctc_pkg::DCTC_IN_GATE)  ? (tclk_tick && ext_sync_q)
                 : tclk_tick;                                                     // see R1
  assign c1_trig_load = !clk_src1_q && ext_rise && timer_mode_ctrl_q[dctc_pkg::TM_C1_EN]
                     && (in_mode == dctc_pkg::DCTC_IN_RETRIG
                         || (in_mode == dctc_pkg::DCTC_IN_TRIG && !(c1_active && c1_fired_q)));  // see R1
  assign c1_load = (wr_mode && wbyte[dctc_pkg::TM_C1_LOAD]) || c1_trig_load;     // see R4
  assign c0_load = wr_mode && wbyte[dctc_pkg::TM_C0_LOAD];                       // see R5

  // ----------------------------------------------------------------
  // Prescalers and counters
  // ----------------------------------------------------------------
  logic        prescale1_ctrl_pulse;
  logic        prescale0_ctrl_pulse;
  logic [7:0]  value1;
  logic [7:0]  value0;
  logic        c0_active;
  logic        eoc1;
  logic        eoc0;
  logic        c1_run;
  logic        c0_run;
  logic        c1_trig_armed;

  // Trigger modes hold off counting until the first trigger
  assign c1_trig_armed = clk_src1_q || !in_mode[1] || (c1_active && c1_fired_q);
  assign c1_run = timer_mode_ctrl_q[dctc_pkg::TM_C1_EN] && c1_trig_armed;  // see R2
  assign c0_run = timer_mode_ctrl_q[dctc_pkg::TM_C0_EN];                  // see R3

  dctc_prescaler u_prescale1_ctrl (
    .clk     (clk),
    .srst    (srst),
    .restart (c1_load),
    .tick    (c1_tick && c1_run),
    .div     (div1_q),
    .pulse   (prescale1_ctrl_pulse)
  );

  dctc_prescaler u_prescale0_ctrl (
    .clk     (clk),
    .srst    (srst),
    .restart (c0_load),
    .tick    (tclk_tick && c0_run),
    .div     (div0_q),
    .pulse   (prescale0_ctrl_pulse)
  );

  dctc_down_counter u_cnt1 (
    .clk    (clk),
    .srst   (srst),
    .load   (c1_load),
    .run    (c1_run),
    .step   (prescale1_ctrl_pulse),
    .modulo (modulo1_q),
    .init   (init1_q),
    .value  (value1),
    .active (c1_active),
    .eoc    (eoc1)
  );

  dctc_down_counter u_cnt0 (
    .clk    (clk),
    .srst   (srst),
    .load   (c0_load),
    .run    (c0_run),
    .step   (prescale0_ctrl_pulse),
    .modulo (modulo0_q),
    .init   (init0_q),
    .value  (value0),
    .active (c0_active),
    .eoc    (eoc0)
  );

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Load bits are strobes; they never stay set in the mode register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_mode_ctrl_q <= dctc_pkg::TIMER_MODE_RST;
      init1_q    <= dctc_pkg::COUNT_RST;
      init0_q    <= dctc_pkg::COUNT_RST;
      div1_q     <= dctc_pkg::DIV_RST;
      div0_q     <= dctc_pkg::DIV_RST;
      clk_src1_q <= 1'b0;
      c1_fired_q <= 1'b0;
      modulo1_q  <= 1'b0;
      modulo0_q  <= 1'b0;
      irq_mask_q <= dctc_pkg::IRQ_MASK_RST;
    end
    else
    begin
      c1_fired_q <= c1_trig_load || (c1_fired_q && !c1_load);  // see R1
      if (wr_mode)
        timer_mode_ctrl_q <= wbyte & 8'h3A;    // see R2, see R3
      if (wr_cnt1)
        init1_q <= wbyte;                         // see R6
      if (wr_cnt0)
        init0_q <= wbyte;                         // see R7
      if (wr_prescale1_ctrl)
      begin
        div1_q     <= wbyte[dctc_pkg::PS_DIV_LO +: 6];   // see R8
        clk_src1_q <= wbyte[dctc_pkg::PS_CLK_SRC];       // see R10
        modulo1_q  <= wbyte[dctc_pkg::PS_MODULO];        // see R11
      end
      if (wr_prescale0_ctrl)
      begin
        div0_q    <= wbyte[dctc_pkg::PS_DIV_LO +: 6];    // see R9
        modulo0_q <= wbyte[dctc_pkg::PS_MODULO];         // see R11
      end
      if (wr_mask)
        irq_mask_q <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [7:0] irq_set;

  assign irq_set = {2'b00, eoc1, eoc0, 4'h0};   // see R12

  // Read clears, but an event in the same cycle wins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_status_q     <= 8'h00;
      irq              <= 1'b0;
      counter_zero_irq <= 1'b0;
      counter_one_irq  <= 1'b0;
    end
    else
    begin
      irq_status_q     <= (rd_status ? 8'h00 : irq_status_q) | irq_set;
      irq              <= |(irq_status_q & irq_mask_q);
      counter_zero_irq <= irq_status_q[dctc_pkg::IRQ_C0_BIT];   // see R12
      counter_one_irq  <= irq_status_q[dctc_pkg::IRQ_C1_BIT];   // see R12
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 10'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? dctc_pkg::DCTC_RESP_OKAY : dctc_pkg::DCTC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  // Prescale registers are write-only and read back zero
  assign rd_byte = hit(s_axi_araddr, dctc_pkg::IDX_TIMER_MODE) ? timer_mode_ctrl_q
                 : hit(s_axi_araddr, dctc_pkg::IDX_COUNT1)     ? value1     // see R6
                 : hit(s_axi_araddr, dctc_pkg::IDX_COUNT0)     ? value0     // see R7
                 : hit(s_axi_araddr, dctc_pkg::IDX_IRQ_STATUS) ? irq_status_q
                 : hit(s_axi_araddr, dctc_pkg::IDX_IRQ_MASK)   ? irq_mask_q
                 : 8'h00;
  assign rd_ok = hit(s_axi_araddr, dctc_pkg::IDX_TIMER_MODE)
              || hit(s_axi_araddr, dctc_pkg::IDX_COUNT1) || hit(s_axi_araddr, dctc_pkg::IDX_COUNT0)
              || hit(s_axi_araddr, dctc_pkg::IDX_IRQ_STATUS) || hit(s_axi_araddr, dctc_pkg::IDX_IRQ_MASK)
              || hit(s_axi_araddr, dctc_pkg::IDX_PRESCALE1) || hit(s_axi_araddr, dctc_pkg::IDX_PRESCALE0);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b0
                     : (!s_axi_arready && !s_axi_rvalid);
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_ok ? dctc_pkg::DCTC_RESP_OKAY : dctc_pkg::DCTC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dctc_top

`default_nettype wire

// >>> sim/dctc_props.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Bus handshake and interrupt properties
// ----------------------------------------------------------------
module dctc_props (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        counter_zero_irq,
  input wire logic        counter_one_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Answers must stand until the master takes them
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  // Registers are one byte wide, so the upper lanes stay quiet
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1 && s_axi_bresp != 2'h3)
    else $error("illegal write response code");
  a_irq_cause: assert property (irq |-> counter_zero_irq || counter_one_irq)
    else $error("interrupt without a pending counter event");

  // Main scenarios reached
  c_zero_end: cover property (counter_zero_irq);
  c_one_end: cover property (counter_one_irq);
  c_irq_out: cover property (irq);
endmodule : dctc_props

`default_nettype wire

// >>> sim/dctc_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the dual counter/timer
// ----------------------------------------------------------------
module dctc_top_tb_top;
  localparam logic [9:0] A_MODE = {dctc_pkg::IDX_TIMER_MODE, 2'b00};
  localparam logic [9:0] A_CNT1 = {dctc_pkg::IDX_COUNT1, 2'b00};
  localparam logic [9:0] A_PRESCALE1_CTRL = {dctc_pkg::IDX_PRESCALE1, 2'b00};
  localparam logic [9:0] A_CNT0 = {dctc_pkg::IDX_COUNT0, 2'b00};
  localparam logic [9:0] A_PRESCALE0_CTRL = {dctc_pkg::IDX_PRESCALE0, 2'b00};
  localparam logic [9:0] A_STAT = {dctc_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_MASK = {dctc_pkg::IDX_IRQ_MASK, 2'b00};
  logic clk = 1'b0, srst = 1'b1, external_timing_input = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic counter_zero_irq, counter_one_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, num_checks = 0, cyc = 0;

  dctc_top dctc_top_inst (.clk(clk), .srst(srst), .external_timing_input(external_timing_input),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .counter_zero_irq(counter_zero_irq), .counter_one_irq(counter_one_irq));

  // 25 MHz clock and a hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One bus transfer; holds every channel until its own ready
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    forever
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic [1:0] r;
    xfer(1'b1, a, d, x, r);
    chk({30'h0, r}, 32'h0000_0000, "write resp");
  endtask : wr

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0] r;
    xfer(1'b0, a, 8'h00, x, r);
    chk(x, e, "read data");
    chk({30'h0, r}, {30'h0, er}, "read resp");
  endtask : rd_chk

  // Waits for a counter event and times it
  task automatic wait_irq(input logic one, input int lo, input int hi);
    int n;
    n = 0;
    while ((one ? counter_one_irq : counter_zero_irq) !== 1'b1 && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= lo && n < hi), 32'h0000_0001, "event timing");
  endtask : wait_irq

  task automatic s_reset();
    rd_chk(A_MODE, 32'h0000_0000, 2'h0);
    rd_chk(A_PRESCALE1_CTRL, 32'h0000_0000, 2'h0);
    rd_chk(10'h000, 32'h0000_0000, 2'h2);
  endtask : s_reset

  // Single pass on counter zero, disable bit, masked interrupt
  task automatic s_single();
    wr(A_PRESCALE0_CTRL, 8'h04);
    wr(A_CNT0, 8'h03);
    wr(A_MASK, 8'h10);
    wr(A_MODE, 8'h03);
    wait_irq(1'b0, 6, 40);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001, "irq out");
    rd_chk(A_MODE, 32'h0000_0002, 2'h0);
    repeat (20) @(posedge clk);
    rd_chk(A_CNT0, 32'h0000_0000, 2'h0);
    rd_chk(A_STAT, 32'h0000_0010, 2'h0);
    rd_chk(A_STAT, 32'h0000_0000, 2'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    wr(A_CNT0, 8'h05);
    wr(A_MODE, 8'h01);
    repeat (40) @(posedge clk);
    rd_chk(A_CNT0, 32'h0000_0005, 2'h0);
  endtask : s_single

  // Divide field 0 means 64, count 0 means 256
  task automatic s_bounds();
    wr(A_PRESCALE1_CTRL, 8'h02);
    wr(A_CNT1, 8'h01);
    wr(A_MODE, 8'h0C);
    wait_irq(1'b1, 200, 330);
    rd_chk(A_STAT, 32'h0000_0020, 2'h0);
    wr(A_PRESCALE0_CTRL, 8'h04);
    wr(A_CNT0, 8'h00);
    wr(A_MODE, 8'h03);
    wait_irq(1'b0, 900, 1100);
    rd_chk(A_STAT, 32'h0000_0010, 2'h0);
  endtask : s_bounds

  // Modulo-N reloads and raises the event again
  task automatic s_modulo();
    logic [31:0] x;
    logic [1:0] r;
    wr(A_PRESCALE0_CTRL, 8'h05);
    wr(A_CNT0, 8'h02);
    wr(A_MODE, 8'h03);
    wait_irq(1'b0, 4, 40);
    rd_chk(A_STAT, 32'h0000_0010, 2'h0);
    @(posedge clk);
    wait_irq(1'b0, 2, 40);
    xfer(1'b0, A_CNT0, 8'h00, x, r);
    chk(32'(x == 32'h1 || x == 32'h2), 32'h0000_0001, "reloaded value");
    wr(A_MODE, 8'h00);
    xfer(1'b0, A_STAT, 8'h00, x, r);
  endtask : s_modulo

  // Every use of the external input: idle-low pin must not count
  task automatic s_ext();
    for (int m = 0; m < 4; m++)
    begin
      external_timing_input <= 1'b0;
      wr(A_PRESCALE1_CTRL, 8'h04);
      wr(A_CNT1, 8'h02);
      wr(A_MODE, {2'b00, 2'(m), 4'hC});
      repeat (40) @(posedge clk);
      rd_chk(A_CNT1, 32'h0000_0002, 2'h0);
      repeat (3)
      begin
        external_timing_input <= 1'b1;
        repeat (8) @(posedge clk);
        external_timing_input <= 1'b0;
        repeat (8) @(posedge clk);
      end
      external_timing_input <= 1'b1;
      wait_irq(1'b1, 0, 60);
      rd_chk(A_STAT, 32'h0000_0020, 2'h0);
    end
  endtask : s_ext

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    s_reset();
    s_single();
    s_bounds();
    s_modulo();
    s_ext();
    end_of_test();
  end
endmodule : dctc_top_tb_top

bind dctc_top dctc_props dctc_props_inst (.clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
  .counter_zero_irq(counter_zero_irq), .counter_one_irq(counter_one_irq));

`default_nettype wire
